// ==== core/rbc_pkg.sv ====
// Contract
// R1 - Power-on, brown-out, external pin, watchdog, reset instruction, stack overflow, stack underflow and programming-mode exit each reset the device.
// R2 - While the power-on detector reports low supply the internal reset stays asserted.
// R3 - When enabled, the power-up delay keeps the device in reset for nominally 64 ms after a power-on or brown-out reset.
// R4 - The power-up delay is enabled only when its active-low enable bit is zero.
// R5 - The power-up delay count begins only after both power-on and brown-out conditions are released.
// R6 - A two-bit mode field selects 11 always on, 10 off in sleep, 01 software controlled, 00 always off with immediate start-up.
// R7 - In always-on mode start-up waits for detector ready and supply above threshold, protection stays on in sleep, and wake-up is not delayed.
// R8 - In off-in-sleep mode start-up waits for ready and supply, protection is off in sleep, and wake-up waits until the detector is ready again.
// R9 - In software mode the soft enable bit switches the detector; in other modes the bit is still read and written but has no effect.
// R10 - In software mode start-up does not wait for detector ready or supply level.
// R11 - In software mode protection acts as soon as the detector is ready and does not change with sleep.
// R12 - A read-only ready flag is one while the detector circuit is active and zero otherwise.
// R13 - When the mode forces the detector on, the ready flag already reads one before execution starts.
// R14 - A brown-out reset fires only if supply stays below threshold longer than a minimum time; shorter dips are ignored.
// R15 - The brown-out trip level is selected by a single configuration bit.
// R16 - The power-up delay counts ticks of the free-running low-frequency oscillator and restarts whenever a power-on or brown-out condition reasserts.
package rbc_pkg;
    localparam logic [3:0] BRC_OFFSET = 4'h0;
    localparam logic [3:0] IRQ_STATUS_OFFSET = 4'h4;
    localparam logic [3:0] IRQ_MASK_OFFSET = 4'h8;

    localparam int SOFT_EN_BIT = 7;
    localparam int READY_BIT = 0;
    localparam logic SOFT_EN_RESET = 1'b1;

    localparam int EV_BROWNOUT = 0;
    localparam int EV_READY_RISE = 1;
    localparam int EV_STARTED = 2;
    localparam int EV_OTHER_RESET = 3;
    localparam int EV_COUNT = 4;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

    localparam int CLK_PERIOD_NS = 20;
    localparam int POWER_UP_DELAY_MS = 64;
    localparam int LF_TICK_PERIOD_US = 32;
    localparam int POWER_UP_DELAY_TICKS =
        POWER_UP_DELAY_MS * 1000 / LF_TICK_PERIOD_US;
    localparam int BROWNOUT_GLITCH_TIME_NS = 1000;
    localparam int BROWNOUT_GLITCH_CYCLES =
        (BROWNOUT_GLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        DETECTOR_ALWAYS_OFF = 2'b00,
        DETECTOR_SOFTWARE_CTL = 2'b01,
        DETECTOR_OFF_IN_SLEEP = 2'b10,
        DETECTOR_ALWAYS_ON = 2'b11
    } rbc_mode_t;

    typedef struct packed {
        rbc_mode_t brownout_mode_select;
        logic brownout_level_select;
        logic power_up_delay_enable_n;
    } rbc_config_t;

    typedef struct packed {
        logic watchdog_reset;
        logic reset_instruction;
        logic stack_overflow;
        logic stack_underflow;
        logic prog_mode_exit;
    } rbc_sources_t;
endpackage

// ==== core/rbc_reset_and_brownout_control.sv ====
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module rbc_reset_and_brownout_control
    import rbc_pkg::*;
#(
    parameter int POWER_UP_TICKS = POWER_UP_DELAY_TICKS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire rbc_config_t config_i,
    input wire rbc_sources_t sources_i,
    input wire logic power_on_low_i,
    input wire logic supply_below_i,
    input wire logic detector_ready_i,
    input wire logic external_reset_pin_n_i,
    input wire logic lf_osc_i,
    input wire logic sleep_i,
    output logic device_reset_o,
    output logic detector_enable_o,
    output logic brownout_level_o,
    output logic wake_hold_o,
    output logic irq_o
);
    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_DELAY = 2'b01,
        ST_RUN = 2'b10
    } rbc_state_t;

    // Analog and pin inputs: two-stage synchronisers, stage one read only
    // by stage two
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic lf_prev_reg;
    logic por_low;
    logic below;
    logic det_ready;
    logic pin_n;
    logic lf_tick;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 5'h1F;
            sync2_reg <= 5'h1F;
            // Matches the synchroniser reset level, so no false tick
            lf_prev_reg <= 1'b1;
        end else begin
            sync1_reg <= {power_on_low_i, supply_below_i, detector_ready_i,
                          external_reset_pin_n_i, lf_osc_i};
            sync2_reg <= sync1_reg;
            lf_prev_reg <= sync2_reg[0];
        end
    end

    assign por_low = sync2_reg[4];
    assign below = sync2_reg[3];
    assign det_ready = sync2_reg[2];
    assign pin_n = sync2_reg[1];
    assign lf_tick = sync2_reg[0] & ~lf_prev_reg; // R16

    logic soft_en_reg;
    logic det_enable;
    logic ready_flag;
    logic protect;
    logic forced_mode;
    rbc_mode_t mode;

    assign mode = config_i.brownout_mode_select;
    assign brownout_level_o = config_i.brownout_level_select; // R15

    always_comb begin
        case (mode) // R6
            DETECTOR_ALWAYS_ON: det_enable = 1'b1; // R7
            DETECTOR_OFF_IN_SLEEP: det_enable = ~sleep_i; // R8
            DETECTOR_SOFTWARE_CTL: det_enable = soft_en_reg; // R9 R11
            DETECTOR_ALWAYS_OFF: det_enable = 1'b0;
            default: det_enable = 1'b0;
        endcase
    end

    assign detector_enable_o = det_enable;
    assign ready_flag = det_enable & det_ready; // R12
    assign protect = ready_flag; // R11
    // Forced modes wait for the detector, so the flag reads one at start
    assign forced_mode = (mode == DETECTOR_ALWAYS_ON) ||
                         (mode == DETECTOR_OFF_IN_SLEEP); // R13
    // Wake from sleep in off-in-sleep mode waits for the detector
    assign wake_hold_o = (mode == DETECTOR_OFF_IN_SLEEP) &
                         ~det_ready; // R8

    // Dip filter; counter saturates so long dips do not wrap
    logic [15:0] glitch_cnt_reg;
    logic trip;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            glitch_cnt_reg <= 16'h0000;
        end else if (!(protect && below)) begin
            glitch_cnt_reg <= 16'h0000; // R14
        end else if (!trip) begin
            glitch_cnt_reg <= glitch_cnt_reg + 16'h0001;
        end
    end

    assign trip = glitch_cnt_reg > 16'(BROWNOUT_GLITCH_CYCLES); // R14

    logic bor_hold_reg;

    // Brown-out reset holds until supply recovers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bor_hold_reg <= 1'b0;
        end else if (trip) begin
            bor_hold_reg <= 1'b1; // R14
        end else if (!below) begin
            bor_hold_reg <= 1'b0;
        end
    end

    logic startup_wait;
    logic cond;
    logic restart;
    rbc_state_t state_reg;
    rbc_state_t state_next;
    logic [15:0] power_up_delay_timer_cnt_reg;
    logic power_up_delay_timer_done;

    // Start-up wait applies only to modes that force the detector on, and
    // only gates leaving hold: once running, dips go through the filter
    assign startup_wait = forced_mode & (~det_ready | below); // R7 R8 R10
    assign restart = por_low | bor_hold_reg |
                     sources_i.prog_mode_exit; // R2 R5
    assign cond = restart | startup_wait;
    assign power_up_delay_timer_done = power_up_delay_timer_cnt_reg >= 16'(POWER_UP_TICKS); // R3

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_HOLD: begin
                if (!cond) begin
                    if (!config_i.power_up_delay_enable_n) begin
                        state_next = ST_DELAY; // R4 R5
                    end else begin
                        state_next = ST_RUN;
                    end
                end
            end
            ST_DELAY: begin
                if (restart) begin
                    state_next = ST_HOLD; // R16
                end else if (power_up_delay_timer_done) begin
                    state_next = ST_RUN; // R3
                end
            end
            ST_RUN: begin
                if (restart) begin
                    state_next = ST_HOLD;
                end
            end
            default: state_next = ST_HOLD;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_up_delay_timer_cnt_reg <= 16'h0000;
        end else if (state_reg != ST_DELAY) begin
            power_up_delay_timer_cnt_reg <= 16'h0000; // R16
        end else if (lf_tick && !power_up_delay_timer_done) begin
            power_up_delay_timer_cnt_reg <= power_up_delay_timer_cnt_reg + 16'h0001; // R16
        end
    end

    logic other_src;
    logic dev_rst_reg;

    assign other_src = sources_i.watchdog_reset |
                       sources_i.reset_instruction |
                       sources_i.stack_overflow |
                       sources_i.stack_underflow | ~pin_n; // R1

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dev_rst_reg <= 1'b1;
        end else begin
            dev_rst_reg <= (state_next != ST_RUN) | other_src; // R1 R2
        end
    end

    assign device_reset_o = dev_rst_reg;

    // Register bus
    logic req;
    logic wr;
    logic [3:0] status_reg;
    logic [3:0] mask_reg;
    logic [3:0] events;
    logic ready_prev_reg;
    logic started_prev_reg;

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i & wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soft_en_reg <= SOFT_EN_RESET;
        end else if (wr && wb_adr_i == BRC_OFFSET) begin
            soft_en_reg <= wb_dat_i[SOFT_EN_BIT]; // R9
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= IRQ_MASK_RESET;
        end else if (wr && wb_adr_i == IRQ_MASK_OFFSET) begin
            mask_reg <= wb_dat_i[EV_COUNT-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Synchronised ready resets high, so no false rise after reset
            ready_prev_reg <= 1'b1;
            started_prev_reg <= 1'b0;
        end else begin
            ready_prev_reg <= ready_flag;
            started_prev_reg <= (state_reg == ST_RUN);
        end
    end

    always_comb begin
        events = 4'h0;
        events[EV_BROWNOUT] = trip & ~bor_hold_reg;
        events[EV_READY_RISE] = ready_flag & ~ready_prev_reg;
        events[EV_STARTED] = (state_reg == ST_RUN) & ~started_prev_reg;
        events[EV_OTHER_RESET] = other_src | sources_i.prog_mode_exit;
    end

    // A new event wins over a clearing write in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= 4'h0;
        end else if (wr && wb_adr_i == IRQ_STATUS_OFFSET) begin
            status_reg <= (status_reg & ~wb_dat_i[EV_COUNT-1:0]) | events;
        end else begin
            status_reg <= status_reg | events;
        end
    end

    assign irq_o = |(status_reg & mask_reg);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= 32'h0000_0000;
            case (wb_adr_i)
                BRC_OFFSET: begin
                    wb_dat_o[SOFT_EN_BIT] <= soft_en_reg;
                    wb_dat_o[READY_BIT] <= ready_flag; // R12
                end
                IRQ_STATUS_OFFSET: wb_dat_o[EV_COUNT-1:0] <= status_reg;
                IRQ_MASK_OFFSET: wb_dat_o[EV_COUNT-1:0] <= mask_reg;
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== tb/rbc_reset_and_brownout_control_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module rbc_checker
    import rbc_pkg::*;
#(
    parameter int POWER_UP_TICKS = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire rbc_config_t config_i,
    input wire rbc_sources_t sources_i,
    input wire logic power_on_low_i,
    input wire logic supply_below_i,
    input wire logic external_reset_pin_n_i,
    input wire logic sleep_i,
    input wire logic device_reset_o,
    input wire logic detector_enable_o,
    input wire logic brownout_level_o,
    input wire logic wake_hold_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    rbc_mode_t mode;
    logic calm;
    assign mode = config_i.brownout_mode_select;
    // Nothing that may hold reset in modes 00 and 01 is active
    assign calm = config_i.power_up_delay_enable_n && !mode[1] &&
        sources_i == '0 && external_reset_pin_n_i && !power_on_low_i &&
        !supply_below_i;
    a_level_copy: assert property (
        brownout_level_o == config_i.brownout_level_select)
        else $error("level output differs");
    a_por_hold: assert property (
        power_on_low_i [*5] |=> device_reset_o)
        else $error("reset released at low supply");
    a_off_mode: assert property (
        mode == DETECTOR_ALWAYS_OFF |-> !detector_enable_o)
        else $error("detector on in off mode");
    a_on_mode: assert property (
        mode == DETECTOR_ALWAYS_ON |-> detector_enable_o)
        else $error("detector off in on mode");
    a_sleep_off: assert property (
        mode == DETECTOR_OFF_IN_SLEEP && sleep_i |-> !detector_enable_o)
        else $error("detector on in sleep");
    a_wake_hold: assert property (
        wake_hold_o |-> mode == DETECTOR_OFF_IN_SLEEP)
        else $error("wake held outside mode 10");
    a_ready_read: assert property (
        wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == BRC_OFFSET &&
        !$past(detector_enable_o) |-> !wb_dat_o[READY_BIT])
        else $error("ready read high with detector off");
    a_fast_start: assert property (
        calm [*8] |-> !device_reset_o)
        else $error("start-up delayed without cause");
endmodule
bind rbc_reset_and_brownout_control rbc_checker
    #(.POWER_UP_TICKS(POWER_UP_TICKS)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .config_i(config_i),
    .sources_i(sources_i), .power_on_low_i(power_on_low_i),
    .supply_below_i(supply_below_i), .sleep_i(sleep_i),
    .external_reset_pin_n_i(external_reset_pin_n_i),
    .device_reset_o(device_reset_o), .detector_enable_o(detector_enable_o),
    .brownout_level_o(brownout_level_o), .wake_hold_o(wake_hold_o));
`default_nettype wire

// ==== tb/rbc_testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import rbc_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, por = 1, below = 0;
    logic rdy = 0, pin_n = 1, lf = 0, slp = 0, ack, dev_rst, det_en;
    logic lvl, hold, irq;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, r;
    rbc_config_t cfg = '{DETECTOR_ALWAYS_ON, 1'b0, 1'b1};
    rbc_sources_t src = '0;
    logic [31:0] exp_q[$];
    int fails = 0, n_compared = 0, cycles = 0, seed = 32'hFF6EAD6B;

    rbc_reset_and_brownout_control #(.POWER_UP_TICKS(4)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .config_i(cfg), .sources_i(src),
        .power_on_low_i(por), .supply_below_i(below),
        .detector_ready_i(rdy), .external_reset_pin_n_i(pin_n),
        .lf_osc_i(lf), .sleep_i(slp), .device_reset_o(dev_rst),
        .detector_enable_o(det_en), .brownout_level_o(lvl),
        .wake_hold_o(hold), .irq_o(irq));

    initial forever #10 clk_i = ~clk_i;

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic flag(input logic g, input logic e);
        check({31'h0, g}, {31'h0, e});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (!ack);
        cyc <= 0;
        we <= 0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(0, a, 32'h0);
    endtask

    // Each rising edge of the slow oscillator is one delay tick
    task automatic lfp(input int n);
        repeat (n) begin
            lf <= 1;
            tick(4);
            lf <= 0;
            tick(4);
        end
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (ack && !we)
            check(rdat, exp_q.pop_front());
        if (cycles == 20000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        tick(10);
        rst_i <= 0;
        por <= 0;
        tick(12);
        flag(dev_rst, 1);
        rdy <= 1;
        tick(8);
        flag(dev_rst, 0);
        rd(BRC_OFFSET, 32'h81);
        rd(4'hC, 32'h0);
        rd(IRQ_MASK_OFFSET, 32'h0);
        r = $random(seed);
        bus(1, BRC_OFFSET, r);
        rd(BRC_OFFSET, {24'h0, r[7], 7'h1});
        bus(1, BRC_OFFSET, 32'h80);
        for (int m = 0; m < 4; m++) begin
            cfg.brownout_mode_select <= rbc_mode_t'(m);
            tick(10);
            flag(det_en, m != 0);
        end
        cfg.brownout_mode_select <= DETECTOR_SOFTWARE_CTL;
        bus(1, BRC_OFFSET, 32'h0);
        flag(det_en, 0);
        rd(BRC_OFFSET, 32'h0);
        bus(1, BRC_OFFSET, 32'h80);
        flag(det_en, 1);
        rdy <= 0;
        below <= 1;
        por <= 1;
        tick(6);
        por <= 0;
        tick(10);
        flag(dev_rst, 0);
        rdy <= 1;
        slp <= 1;
        tick(70);
        flag(dev_rst, 1);
        below <= 0;
        tick(8);
        flag(dev_rst, 0);
        cfg.brownout_mode_select <= DETECTOR_OFF_IN_SLEEP;
        rdy <= 0;
        tick(4);
        flag(det_en, 0);
        flag(hold, 1);
        rdy <= 1;
        tick(4);
        flag(hold, 0);
        slp <= 0;
        cfg.brownout_mode_select <= DETECTOR_ALWAYS_ON;
        cfg.brownout_level_select <= 1;
        below <= 1;
        tick(30);
        flag(lvl, 1);
        flag(dev_rst, 0);
        below <= 0;
        tick(8);
        flag(dev_rst, 0);
        below <= 1;
        tick(70);
        flag(dev_rst, 1);
        cfg.power_up_delay_enable_n <= 0;
        por <= 1;
        tick(6);
        por <= 0;
        lfp(6);
        flag(dev_rst, 1);
        below <= 0;
        lfp(3);
        flag(dev_rst, 1);
        lfp(3);
        flag(dev_rst, 0);
        cfg.power_up_delay_enable_n <= 1;
        for (int i = 0; i < 6; i++) begin
            {pin_n, src} <= {i != 5, 5'h1 << i};
            tick(6);
            flag(dev_rst, 1);
            {pin_n, src} <= 6'h20;
            tick(8);
            flag(dev_rst, 0);
        end
        rd(IRQ_STATUS_OFFSET, 32'hF);
        bus(1, IRQ_STATUS_OFFSET, 32'hF);
        bus(1, IRQ_MASK_OFFSET, 32'h8);
        flag(irq, 0);
        src <= rbc_sources_t'(5'h10);
        tick(2);
        src <= '0;
        tick(8);
        flag(irq, 1);
        rd(IRQ_STATUS_OFFSET, 32'h8);
        bus(1, IRQ_STATUS_OFFSET, 32'hF);
        flag(irq, 0);
        rd(IRQ_STATUS_OFFSET, 32'h0);
        bus(1, IRQ_MASK_OFFSET, 32'h0);
        src <= rbc_sources_t'(5'h10);
        tick(2);
        src <= '0;
        tick(8);
        flag(irq, 0);
        final_report();
    end
endmodule
`default_nettype wire
